//--- sbc_mcu_digital_interface.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_mcu_digital_interface #(
   parameter int NR_TIMEOUT = sbc_pkg::NR_TIMEOUT_CYC,
   parameter int RST_PULSE = sbc_pkg::RST_PULSE_CYC,
   parameter int CYC_PERIOD = sbc_pkg::CYC_SENSE_CYC,
   parameter int WD_DEFAULT = sbc_pkg::WD_DEFAULT_CYC,
   parameter int WD_RESISTOR = sbc_pkg::WD_RESISTOR_CYC
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic txd,
   output logic rxd,
   input wire logic lin_bus_in,
   output logic lin_dominant,
   input wire logic reset_line_in,
   output logic reset_line_out,
   output logic reset_line_oe,
   output logic irq_n,
   input wire logic pulse_width_ctrl_in,
   input wire logic [1:0] watchdog_strap,
   input wire logic event_in,
   input wire logic multi_input_1,
   input wire logic multi_input_2,
   input wire logic multi_input_3,
   input wire logic multi_input_4,
   output logic high_switch_a,
   output logic high_switch_b,
   output logic low_switch_a,
   output logic low_switch_b,
   output logic [2:0] analog_mux_sel,
   output logic [1:0] sense_gain,
   output logic [2:0] mode_state,
   output logic watchdog_enable,
   output logic [31:0] watchdog_period
);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   sbc_pkg::pin_in_t pin_raw, sync1_q, sync2_q, sync3_q;

   assign pin_raw = '{cs_n: cs_n, sclk: sclk, mosi: mosi, txd: txd,
                      lin_bus: lin_bus_in, rst_line: reset_line_in,
                      pwm: pulse_width_ctrl_in, evt: event_in,
                      multi: {multi_input_4, multi_input_3,
                              multi_input_2, multi_input_1},
                      strap: watchdog_strap};

   // third stage only feeds edge detection
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sync1_q <= sbc_pkg::PIN_IDLE;
         sync2_q <= sbc_pkg::PIN_IDLE;
         sync3_q <= sbc_pkg::PIN_IDLE;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   logic cs_rise, cs_fall, sclk_rise, sclk_fall, cs_low;
   assign cs_low = !sync2_q.cs_n;
   assign cs_rise = sync2_q.cs_n && !sync3_q.cs_n;
   assign cs_fall = !sync2_q.cs_n && sync3_q.cs_n;
   assign sclk_rise = sync2_q.sclk && !sync3_q.sclk;
   assign sclk_fall = !sync2_q.sclk && sync3_q.sclk;

   // ****************************************************************
   // state shared by several sections
   // ****************************************************************
   sbc_pkg::mode_t mode_q;
   logic [4:0] high_side_ctrl_reg_q, low_side_ctrl_reg_q, analog_ctrl_q;
   logic wake_flag_q, event_flag_q, wd_en_q;
   logic [3:0] in_enabled, in_digital;
   logic active_mode, low_power, link_active;

   assign active_mode = (mode_q == sbc_pkg::MODE_NREQ) ||
                        (mode_q == sbc_pkg::MODE_NORMAL);
   assign low_power = (mode_q == sbc_pkg::MODE_STOP) ||
                      (mode_q == sbc_pkg::MODE_SLEEP);
   assign link_active = active_mode;

   // inputs routed to the analog mux lose digital and wake use
   function automatic logic [3:0] digital_mask(input logic [2:0] sel);
      logic [3:0] m;
      m = 4'hF;
      for (int i = 0; i < 4; i++) begin
         if (sel == 3'(i + 1)) begin
            m[i] = 1'b0;
         end
      end
      return m;
   endfunction

   assign in_enabled = digital_mask(analog_ctrl_q[2:0]);
   assign in_digital = sync2_q.multi & in_enabled;

   // ****************************************************************
   // serial shift engine
   // ****************************************************************
   logic [7:0] rx_shift_q, tx_shift_q;
   logic [3:0] bit_cnt_q;
   sbc_pkg::status_t snap_q, status_now;
   sbc_pkg::spi_cmd_t cmd;
   logic xfer_ok, wr_mode, rd_status;

   assign status_now = '{inputs: in_digital, wake: wake_flag_q,
                         event_f: event_flag_q, wd_on: wd_en_q,
                         link_on: link_active};

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rx_shift_q <= 8'h00;
         tx_shift_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         snap_q <= '0;
      end else if (cs_fall) begin
         bit_cnt_q <= 4'h0;
         tx_shift_q <= status_now;
         snap_q <= status_now;
      end else if (cs_low) begin
         if (sclk_rise) begin
            rx_shift_q <= {rx_shift_q[6:0], sync2_q.mosi};
            if (bit_cnt_q != 4'hF) begin
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end
         end
         if (sclk_fall) begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
         end
      end
   end

   // first bit is on the line from the chip select edge onward
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         miso <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         miso_oe <= cs_low;
         if (cs_fall) begin
            miso <= status_now[7];
         end else if (cs_low && sclk_fall) begin
            miso <= tx_shift_q[6];
         end
      end
   end

   // bit counts other than 8 leave every control register and flag untouched, but a chip select rise still ends stop mode
   assign xfer_ok = cs_rise &&
                    (bit_cnt_q == 4'(sbc_pkg::SPI_BITS));
   assign cmd = rx_shift_q;
   assign wr_mode = xfer_ok && (cmd.addr == sbc_pkg::ADDR_MODE);
   assign rd_status = xfer_ok && (cmd.addr == sbc_pkg::ADDR_STATUS);

   // ****************************************************************
   // control registers
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!reset_n || mode_q == sbc_pkg::MODE_RESET) begin
         high_side_ctrl_reg_q <= sbc_pkg::CTRL_RESET;
         low_side_ctrl_reg_q <= sbc_pkg::CTRL_RESET;
         analog_ctrl_q <= sbc_pkg::CTRL_RESET;
      end else if (xfer_ok) begin
         if (cmd.addr == sbc_pkg::ADDR_HIGH_SIDE) begin
            high_side_ctrl_reg_q <= cmd.data;
         end
         if (cmd.addr == sbc_pkg::ADDR_LOW_SIDE) begin
            low_side_ctrl_reg_q <= cmd.data;
         end
         if (cmd.addr == sbc_pkg::ADDR_ANALOG) begin
            analog_ctrl_q <= cmd.data;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         analog_mux_sel <= 3'h0;
         sense_gain <= 2'h0;
      end else begin
         analog_mux_sel <= analog_ctrl_q[sbc_pkg::MUX_LSB +: 3];
         sense_gain <= analog_ctrl_q[sbc_pkg::GAIN_LSB +: 2];
      end
   end

   // ****************************************************************
   // reset line driver and input filter
   // ****************************************************************
   logic [7:0] filt_cnt_q;
   logic ext_reset;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reset_line_oe <= 1'b0;
         reset_line_out <= 1'b0;
      end else begin
         reset_line_oe <= (mode_q == sbc_pkg::MODE_RESET);
         reset_line_out <= 1'b0;
      end
   end

   // our own drive is not counted, else release would re-trigger
   always_ff @(posedge ref_clk) begin
      if (!reset_n || reset_line_oe || sync2_q.rst_line) begin
         filt_cnt_q <= 8'h00;
      end else if (filt_cnt_q != 8'(sbc_pkg::RST_FILT_CYC)) begin
         filt_cnt_q <= filt_cnt_q + 8'h01;
      end
   end

   assign ext_reset = (filt_cnt_q == 8'(sbc_pkg::RST_FILT_CYC));

   // ****************************************************************
   // watchdog strap
   // ****************************************************************
   // caught when the reset pulse ends, so the strap has settled
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wd_en_q <= 1'b0;
         watchdog_enable <= 1'b0;
         watchdog_period <= 32'h0;
      end else begin
         if (mode_q == sbc_pkg::MODE_RESET) begin
            wd_en_q <= (sync2_q.strap != sbc_pkg::STRAP_GND);
            if (sync2_q.strap == sbc_pkg::STRAP_OPEN) begin
               watchdog_period <= 32'(WD_DEFAULT);
            end else begin
               watchdog_period <= 32'(WD_RESISTOR);
            end
         end
         watchdog_enable <= wd_en_q;
      end
   end

   // ****************************************************************
   // wake detection
   // ****************************************************************
   logic [3:0] ref_in_q, sample_q;
   logic have_sample_q, cyc_wake, change_wake, wake_src, cyc_en;
   logic [31:0] cyc_cnt_q;
   logic cyc_on;

   assign cyc_en = high_side_ctrl_reg_q[sbc_pkg::CYC_EN_BIT];
   assign cyc_on = low_power && cyc_en &&
                   (cyc_cnt_q < 32'(sbc_pkg::CYC_ON_CYC));

   always_ff @(posedge ref_clk) begin
      if (!reset_n || !low_power || !cyc_en) begin
         cyc_cnt_q <= 32'h0;
         have_sample_q <= 1'b0;
         sample_q <= 4'h0;
      end else begin
         if (cyc_cnt_q == 32'(CYC_PERIOD - 1)) begin
            cyc_cnt_q <= 32'h0;
         end else begin
            cyc_cnt_q <= cyc_cnt_q + 32'h1;
         end
         if (cyc_cnt_q == 32'(sbc_pkg::CYC_ON_CYC - 1)) begin
            sample_q <= sync2_q.multi;
            have_sample_q <= 1'b1;
         end
      end
   end

   assign cyc_wake = have_sample_q &&
                     (cyc_cnt_q == 32'(sbc_pkg::CYC_ON_CYC - 1)) &&
                     |((sync2_q.multi ^ sample_q) & in_enabled);

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ref_in_q <= 4'h0;
      end else if (!low_power) begin
         ref_in_q <= sync2_q.multi;
      end
   end

   assign change_wake = |((sync2_q.multi ^ ref_in_q) & in_enabled);
   assign wake_src = !sync2_q.lin_bus ||
                     (cyc_en ? cyc_wake : change_wake);

   // ****************************************************************
   // mode sequencing
   // ****************************************************************
   logic [31:0] timer_q;
   sbc_pkg::mode_t mode_d;
   logic stop_irq_wake;

   always_comb begin
      mode_d = mode_q;
      stop_irq_wake = 1'b0;
      unique case (mode_q)
         sbc_pkg::MODE_RESET: begin
            if (timer_q >= 32'(RST_PULSE - 1)) begin
               mode_d = sbc_pkg::MODE_NREQ;
            end
         end
         sbc_pkg::MODE_NREQ: begin
            if (ext_reset) begin
               mode_d = sbc_pkg::MODE_RESET;
            end else if (wr_mode && cmd.data[1:0] ==
                         sbc_pkg::MOD_NORMAL) begin
               mode_d = sbc_pkg::MODE_NORMAL;
            end else if (timer_q >= 32'(NR_TIMEOUT - 1)) begin
               mode_d = wd_en_q ? sbc_pkg::MODE_RESET
                                : sbc_pkg::MODE_NORMAL;
            end
         end
         sbc_pkg::MODE_NORMAL: begin
            if (ext_reset) begin
               mode_d = sbc_pkg::MODE_RESET;
            end else if (wr_mode && cmd.data[1:0] ==
                         sbc_pkg::MOD_STOP) begin
               mode_d = sbc_pkg::MODE_STOP;
            end else if (wr_mode && cmd.data[1:0] ==
                         sbc_pkg::MOD_SLEEP) begin
               mode_d = sbc_pkg::MODE_SLEEP;
            end
         end
         sbc_pkg::MODE_STOP: begin
            if (cs_rise || ext_reset) begin
               mode_d = sbc_pkg::MODE_NREQ;
            end else if (wake_src) begin
               mode_d = sbc_pkg::MODE_NREQ;
               stop_irq_wake = 1'b1;
            end
         end
         sbc_pkg::MODE_SLEEP: begin
            if (wake_src) begin
               mode_d = sbc_pkg::MODE_RESET;
            end
         end
         default: begin
            mode_d = sbc_pkg::MODE_RESET;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         mode_q <= sbc_pkg::MODE_RESET;
         timer_q <= 32'h0;
         mode_state <= sbc_pkg::MODE_RESET;
      end else begin
         mode_q <= mode_d;
         mode_state <= mode_d;
         if (mode_d != mode_q) begin
            timer_q <= 32'h0;
         end else if (timer_q != 32'hFFFF_FFFF) begin
            timer_q <= timer_q + 32'h1;
         end
      end
   end

   // ****************************************************************
   // interrupt flags
   // ****************************************************************
   // a new event in the clearing cycle keeps its flag set
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         event_flag_q <= 1'b0;
         wake_flag_q <= 1'b0;
         irq_n <= 1'b1;
      end else begin
         event_flag_q <= (active_mode && sync2_q.evt) ||
            (event_flag_q && !(rd_status && snap_q.event_f));
         wake_flag_q <= stop_irq_wake ||
            (wake_flag_q && !(rd_status && snap_q.wake));
         irq_n <= !(event_flag_q || wake_flag_q);
      end
   end

   // ****************************************************************
   // switch and bus outputs
   // ****************************************************************
   logic pwm;
   assign pwm = sync2_q.pwm;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         high_switch_a <= 1'b0;
         high_switch_b <= 1'b0;
         low_switch_a <= 1'b0;
         low_switch_b <= 1'b0;
      end else if (active_mode) begin
         high_switch_a <= high_side_ctrl_reg_q[sbc_pkg::SW_A_BIT] &&
            (!high_side_ctrl_reg_q[sbc_pkg::PWM_EN_BIT] || pwm);
         high_switch_b <= high_side_ctrl_reg_q[sbc_pkg::SW_B_BIT] &&
            (!high_side_ctrl_reg_q[sbc_pkg::PWM_EN_BIT] || pwm);
         low_switch_a <= low_side_ctrl_reg_q[sbc_pkg::SW_A_BIT] &&
            (!low_side_ctrl_reg_q[sbc_pkg::PWM_EN_BIT] || pwm);
         low_switch_b <= low_side_ctrl_reg_q[sbc_pkg::SW_B_BIT] &&
            (!low_side_ctrl_reg_q[sbc_pkg::PWM_EN_BIT] || pwm);
      end else begin
         high_switch_a <= cyc_on;
         high_switch_b <= 1'b0;
         low_switch_a <= 1'b0;
         low_switch_b <= 1'b0;
      end
   end

   // a floating transmit pin is held high by the pad pull-up
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rxd <= 1'b1;
         lin_dominant <= 1'b0;
      end else begin
         rxd <= link_active ? sync2_q.lin_bus : 1'b1;
         lin_dominant <= link_active && !sync2_q.txd;
      end
   end

endmodule
`default_nettype wire

//--- sbc_pkg.sv
package sbc_pkg;

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int REF_CLK_HZ = 20_000_000;
   localparam int CYC_PER_MS = REF_CLK_HZ / 1000;
   localparam int NR_TIMEOUT_MS = 150;
   localparam int NR_TIMEOUT_CYC = NR_TIMEOUT_MS * CYC_PER_MS;
   localparam int RST_PULSE_MS = 1;
   localparam int RST_PULSE_CYC = RST_PULSE_MS * CYC_PER_MS;
   localparam int WD_DEFAULT_MS = 150;
   localparam int WD_DEFAULT_CYC = WD_DEFAULT_MS * CYC_PER_MS;
   localparam int WD_RESISTOR_MS = 100;
   localparam int WD_RESISTOR_CYC = WD_RESISTOR_MS * CYC_PER_MS;
   localparam int RST_FILT_US = 4;
   localparam int RST_FILT_CYC =
      (RST_FILT_US * (REF_CLK_HZ / 1000) + 999) / 1000;
   localparam int CYC_SENSE_MS = 50;
   localparam int CYC_SENSE_CYC = CYC_SENSE_MS * CYC_PER_MS;
   localparam int CYC_ON_US = 20;
   localparam int CYC_ON_CYC =
      (CYC_ON_US * (REF_CLK_HZ / 1000) + 999) / 1000;
   localparam int SPI_BITS = 8;

   // ****************************************************************
   // command layout
   // ****************************************************************
   localparam logic [2:0] ADDR_MODE = 3'h0;
   localparam logic [2:0] ADDR_HIGH_SIDE = 3'h1;
   localparam logic [2:0] ADDR_LOW_SIDE = 3'h2;
   localparam logic [2:0] ADDR_ANALOG = 3'h3;
   localparam logic [2:0] ADDR_STATUS = 3'h4;
   localparam int MOD_A_BIT = 0;
   localparam int MOD_B_BIT = 1;
   localparam logic [1:0] MOD_NORMAL = 2'h0;
   localparam logic [1:0] MOD_STOP = 2'h1;
   localparam logic [1:0] MOD_SLEEP = 2'h2;
   localparam int SW_A_BIT = 0;
   localparam int SW_B_BIT = 1;
   localparam int PWM_EN_BIT = 2;
   localparam int CYC_EN_BIT = 3;
   localparam int MUX_LSB = 0;
   localparam int GAIN_LSB = 3;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam logic [1:0] STRAP_GND = 2'h0;
   localparam logic [1:0] STRAP_OPEN = 2'h1;

   typedef enum logic [2:0] {
      MODE_RESET = 3'b000,
      MODE_NREQ = 3'b001,
      MODE_NORMAL = 3'b010,
      MODE_STOP = 3'b011,
      MODE_SLEEP = 3'b100
   } mode_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [4:0] data;
   } spi_cmd_t;

   typedef struct packed {
      logic [3:0] inputs;
      logic wake;
      logic event_f;
      logic wd_on;
      logic link_on;
   } status_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic mosi;
      logic txd;
      logic lin_bus;
      logic rst_line;
      logic pwm;
      logic evt;
      logic [3:0] multi;
      logic [1:0] strap;
   } pin_in_t;

   localparam logic [13:0] PIN_IDLE = 14'h3FFF;

endpackage

//--- sbc_mcu_digital_interface_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_mcu_digital_interface_sva #(
   parameter int RST_PULSE = 50
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic miso_oe,
   input wire logic txd,
   input wire logic rxd,
   input wire logic lin_bus_in,
   input wire logic lin_dominant,
   input wire logic reset_line_out,
   input wire logic reset_line_oe,
   input wire logic irq_n,
   input wire logic event_in,
   input wire logic [2:0] mode_state
);
   logic act;
   logic [7:0] hi_q;
   logic [15:0] oe_q;
   assign act = mode_state == 3'h1 || mode_state == 3'h2;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // cycles since chip select rose, saturating
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !cs_n) hi_q <= 8'h00;
      else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !reset_line_oe) oe_q <= 16'h0000;
      else oe_q <= oe_q + 16'h0001;
   end
   miso_hiz_a:
      assert property (cs_n [*4] |-> !miso_oe) else $error("miso driven");
   link_idle_a:
      assert property ((!act) [*2] |-> rxd && !lin_dominant)
      else $error("link active in low power");
   rx_follow_a:
      assert property ((act && $stable(lin_bus_in)) [*6] |->
         rxd == lin_bus_in) else $error("rxd wrong");
   tx_drive_a:
      assert property ((act && $stable(txd)) [*6] |->
         lin_dominant == !txd) else $error("bus drive wrong");
   rst_start_a:
      assert property ($rose(reset_n) |=> reset_line_oe)
      else $error("no reset pulse");
   rst_len_a:
      assert property ($fell(reset_line_oe) |->
         oe_q >= RST_PULSE - 1 && oe_q <= RST_PULSE + 1)
      else $error("reset pulse length");
   rst_release_a:
      assert property ($fell(reset_line_oe) |-> ##[0:2] mode_state == 3'h1)
      else $error("no normal request");
   rst_drive_a:
      assert property (reset_line_oe |-> !reset_line_out &&
         (mode_state == 3'h0 || $past(mode_state) == 3'h0))
      else $error("reset line not low");
   irq_event_a:
      assert property ((act && event_in) [*4] |-> ##[0:4] !irq_n)
      else $error("irq missing");
   irq_clear_a:
      assert property ($rose(irq_n) |-> mode_state == 3'h0 ||
         (hi_q > 8'h00 && hi_q < 8'h0A)) else $error("irq cleared early");
endmodule
bind sbc_mcu_digital_interface sbc_mcu_digital_interface_sva #(
   .RST_PULSE(RST_PULSE)) chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .cs_n(cs_n), .miso_oe(miso_oe), .txd(txd), .rxd(rxd),
   .lin_bus_in(lin_bus_in), .lin_dominant(lin_dominant),
   .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe),
   .irq_n(irq_n), .event_in(event_in), .mode_state(mode_state));
`default_nettype wire

//--- host_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module host_spi_master (
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // clock idles low; long low phase lets miso settle before the rise
   task automatic xfer(input logic [7:0] c, input int n,
      output logic [7:0] rsp);
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         mosi = c[7-i];
         #250 sclk = 1'b1;
         rsp = {rsp[6:0], miso};
         #150 sclk = 1'b0;
      end
      #250 cs_n = 1'b1;
      mosi = ~mosi;
      #300;
   endtask
endmodule
`default_nettype wire

//--- sbc_mcu_digital_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_mcu_digital_interface_tb_top;
   localparam int WD_DEF = 300;
   localparam int WD_RES = 200;
   logic ref_clk, reset_n, cs_n, sclk, mosi, miso, miso_oe, txd, rxd;
   logic miso_pin;
   logic lin_bus_in, lin_dominant, bus_dom, host_rst, reset_line_in;
   logic reset_line_out, reset_line_oe, irq_n, pwm, event_in;
   logic hsa, hsb, lsa, lsb, wd_en;
   logic [1:0] strap, gain;
   logic [2:0] mux, mode_state;
   logic [3:0] multi;
   logic [7:0] r;
   logic [31:0] wd_per;
   int mismatches, comparisons;
   // open-drain wires with pull-ups
   assign lin_bus_in = ~(lin_dominant | bus_dom);
   assign reset_line_in = ~((reset_line_oe & ~reset_line_out) | host_rst);
   // a released data line shows the opposite of the last bit
   assign miso_pin = miso_oe ? miso : ~miso;
   sbc_mcu_digital_interface #(.NR_TIMEOUT(2000), .RST_PULSE(50),
      .CYC_PERIOD(1000), .WD_DEFAULT(WD_DEF), .WD_RESISTOR(WD_RES)) DUT (
      .ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
      .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .txd(txd), .rxd(rxd),
      .lin_bus_in(lin_bus_in), .lin_dominant(lin_dominant),
      .reset_line_in(reset_line_in), .reset_line_out(reset_line_out),
      .reset_line_oe(reset_line_oe), .irq_n(irq_n),
      .pulse_width_ctrl_in(pwm), .watchdog_strap(strap),
      .event_in(event_in), .multi_input_1(multi[0]),
      .multi_input_2(multi[1]), .multi_input_3(multi[2]),
      .multi_input_4(multi[3]), .high_switch_a(hsa), .high_switch_b(hsb),
      .low_switch_a(lsa), .low_switch_b(lsb), .analog_mux_sel(mux),
      .sense_gain(gain), .mode_state(mode_state),
      .watchdog_enable(wd_en), .watchdog_period(wd_per));
   host_spi_master host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi),
      .miso(miso_pin));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic wait_mode(input logic [2:0] m, input int b);
      for (int i = 0; i < b && mode_state !== m; i++) cyc(1);
      check(mode_state === m, "mode");
      if (mode_state !== m) print_verdict();
   endtask
   task automatic t_reset();
      cyc(2);
      check(reset_line_oe === 1'b1, "rst out");
      wait_mode(3'h1, 200);
      check(wd_en === 1'b1 && wd_per === 32'(WD_DEF), "wd");
      $display("reset done");
   endtask
   task automatic t_link();
      bus_dom = 1'b1;
      cyc(6);
      check(rxd === 1'b0, "rxd");
      bus_dom = 1'b0;
      txd = 1'b0;
      cyc(6);
      check(lin_dominant === 1'b1 && rxd === 1'b0, "tx");
      txd = 1'b1;
      cyc(6);
      check(lin_dominant === 1'b0 && rxd === 1'b1, "rec");
      $display("link done");
   endtask
   task automatic t_switch();
      host.xfer(8'h00, 8, r);
      wait_mode(3'h2, 20);
      host.xfer(8'h23, 8, r);
      cyc(8);
      check(hsa === 1'b1 && hsb === 1'b1, "hs");
      host.xfer(8'h20, 7, r);
      cyc(8);
      check(hsa === 1'b1, "short");
      host.xfer(8'h47, 8, r);
      cyc(8);
      check(lsa === 1'b0 && lsb === 1'b0, "pwm lo");
      pwm = 1'b1;
      cyc(8);
      check(lsa === 1'b1 && lsb === 1'b1, "pwm hi");
      host.xfer(8'h70, 8, r);
      cyc(8);
      check(gain === 2'h2, "gain");
      $display("switch done");
   endtask
   task automatic t_irq();
      multi = 4'hA;
      event_in = 1'b1;
      cyc(8);
      event_in = 1'b0;
      check(irq_n === 1'b0, "irq");
      cyc(20);
      check(irq_n === 1'b0, "irq held");
      host.xfer(8'h80, 8, r);
      check(r === 8'hA7, "status");
      cyc(8);
      check(irq_n === 1'b1, "irq clr");
      multi = 4'hB;
      host.xfer(8'h61, 8, r);
      check(mux === 3'h1 && gain === 2'h0, "mux sel");
      host.xfer(8'h80, 8, r);
      check(r === 8'hA3, "mux");
      $display("irq done");
   endtask
   task automatic t_stop();
      host.xfer(8'h01, 8, r);
      wait_mode(3'h3, 20);
      txd = 1'b0;
      cyc(6);
      check(lin_dominant === 1'b0 && rxd === 1'b1, "idle");
      txd = 1'b1;
      host.xfer(8'h00, 0, r);
      wait_mode(3'h1, 20);
      cyc(2);
      check(irq_n === 1'b1, "cs wake");
      host.xfer(8'h00, 8, r);
      wait_mode(3'h2, 20);
      host.xfer(8'h01, 8, r);
      wait_mode(3'h3, 20);
      multi = 4'hA;
      cyc(10);
      check(mode_state === 3'h3, "masked");
      multi = 4'h8;
      wait_mode(3'h1, 20);
      cyc(2);
      check(irq_n === 1'b0, "in wake");
      host.xfer(8'h80, 8, r);
      check(r[3] === 1'b1, "wake flag");
      $display("stop done");
   endtask
   task automatic t_timeout();
      strap = sbc_pkg::STRAP_GND;
      wait_mode(3'h0, 2100);
      wait_mode(3'h1, 200);
      check(wd_en === 1'b0, "wd off");
      wait_mode(3'h2, 2100);
      host_rst = 1'b1;
      cyc(20);
      host_rst = 1'b0;
      cyc(10);
      check(mode_state === 3'h2, "glitch");
      host_rst = 1'b1;
      cyc(100);
      host_rst = 1'b0;
      wait_mode(3'h1, 200);
      $display("timeout done");
   endtask
   task automatic t_sleep();
      strap = 2'h2;
      host.xfer(8'h00, 8, r);
      wait_mode(3'h2, 20);
      host.xfer(8'h29, 8, r);
      host.xfer(8'h02, 8, r);
      wait_mode(3'h4, 20);
      cyc(10);
      check(hsa === 1'b1, "cyc on");
      cyc(500);
      check(hsa === 1'b0, "cyc off");
      multi = 4'h4;
      wait_mode(3'h0, 2500);
      wait_mode(3'h1, 200);
      check(wd_en === 1'b1 && wd_per === 32'(WD_RES), "wd res");
      $display("sleep done");
   endtask
   initial begin
      mismatches = 0;
      comparisons = 0;
      reset_n = 1'b0;
      txd = 1'b1;
      bus_dom = 1'b0;
      host_rst = 1'b0;
      pwm = 1'b0;
      event_in = 1'b0;
      strap = sbc_pkg::STRAP_OPEN;
      multi = 4'h0;
      cyc(3);
      reset_n = 1'b1;
      t_reset();
      t_link();
      t_switch();
      t_irq();
      t_stop();
      t_timeout();
      t_sleep();
      print_verdict();
   end
endmodule
`default_nettype wire
